/* File: verilog/pci_config_header_io_base.v */
// Configuration words for self-test/header/latency/cache and the I/O base address
// What this block does
// - Self-test capable bit reads zero
// - Self-test start bit reads zero
// - Bits 29 and 28 read zero
// - Completion code reads passed, zero
// - Multifunction flag reads zero
// - Layout type field reads zero
// - Latency timer drives master bus tenure
// - Cache line size unsupported, snoop ignored
// - I/O base decodes PCI I/O commands
// - Base variant: bits 30-20 writable, 1 MB
// - Extended variant: bits 31-8 writable, 256 B
// - I/O base resets to 0x00000001
// - Base variant: bits 19-8 stay zero
// - Bits 7 to 2 always zero
// - Reserved bit 1 reads zero
// - Space indicator bit reads one
// - Only latency timer writable in word
// - Self-test word resets to zero
`timescale 1ns/10ps
`include "pci_cfg_hdr_regs.vh"
module pci_config_header_io_base (
  input  wire        ref_clk_i,       // 250 MHz clock
  input  wire        rstn_i,          // Power-on reset, sync, active low
  input  wire        soft_rstn_i,     // Software reset, sync, active low
  input  wire        ext_variant_i,   // Strap: high selects extended variant
  // PCI configuration side
  input  wire        pci_cfg_wr_i,    // PCI config write strobe
  input  wire        pci_cfg_rd_i,    // PCI config read strobe
  input  wire [5:0]  pci_cfg_idx_i,   // PCI config word index
  input  wire [3:0]  pci_cfg_be_i,    // PCI byte enables, active high
  input  wire [31:0] pci_cfg_wdata_i, // PCI write data
  output reg  [31:0] pci_cfg_rdata_o, // PCI read data, registered
  // Internal peripheral bus side
  input  wire        pp_wr_i,         // Peripheral bus write strobe
  input  wire        pp_rd_i,         // Peripheral bus read strobe
  input  wire [5:0]  pp_idx_i,        // Peripheral bus word index
  input  wire [3:0]  pp_be_i,         // Peripheral bus byte enables
  input  wire [31:0] pp_wdata_i,      // Peripheral bus write data
  output reg  [31:0] pp_rdata_o,      // Peripheral bus read data, registered
  // Decode and master timing
  input  wire [31:0] pci_io_addr_i,   // Address of a PCI I/O cycle
  input  wire        pci_io_cmd_i,    // PCI I/O command present
  output wire        io_hit_o,        // I/O cycle targets local registers
  output reg  [7:0]  master_latency_timer_o, // Latency time while bus master
  output wire        cache_disabled_o // Memory target cache-disabled
);
  reg  [7:0]  master_latency_timer_reg;
  reg  [7:0]  master_latency_timer_next;
  reg  [31:0] io_base_reg;
  reg  [31:0] io_base_next;
  reg         variant_reg;
  wire [31:0] selftest_word;
  wire [31:0] io_base_word;
  wire [31:0] io_wmask;

  // Expand byte enables into a bit mask
  function [31:0] be_mask;
    input [3:0] be;
    begin
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Read mux shared by both ports so they always agree
  function [31:0] cfg_read;
    input [5:0]  idx;
    input [31:0] w3;
    input [31:0] w4;
    begin
      if (idx == `CFG_IDX_SELFTEST_WORD)
        cfg_read = w3;
      else if (idx == `CFG_IDX_IO_BASE_WORD)
        cfg_read = w4;
      else
        cfg_read = 32'h00000000;
    end
  endfunction

  // Strap captured at reset; the variant must not change under live traffic
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      variant_reg <= ext_variant_i;
    end
  end

  // Self-test and header fields are constants; only latency is stored
  assign selftest_word = {`SELFTEST_CAPABLE_VAL,
                          `SELFTEST_START_VAL,
                          `SELFTEST_ZERO_VAL,
                          `SELFTEST_CODE_PASS,
                          `MULTIFUNCTION_VAL,
                          `LAYOUT_TYPE_00,
                          master_latency_timer_reg,
                          `CACHE_LINE_SIZE_VAL};

  // Fixed low bits and indicator are rebuilt on read, never stored
  assign io_base_word = {io_base_reg[31:8],
                         `IO_LOW_FIXED_VAL,
                         `IO_RSVD_VAL,
                         `IO_SPACE_IND_VAL};

  // Writable bits depend on variant; others keep their fixed value
  assign io_wmask = variant_reg ? `IO_WMASK_EXT : `IO_WMASK_BASE;

  // Next-state for latency timer; PCI write wins if both hit same cycle
  always @* begin
    master_latency_timer_next = master_latency_timer_reg;
    if (pp_wr_i && pp_idx_i == `CFG_IDX_SELFTEST_WORD && pp_be_i[1])
      master_latency_timer_next = pp_wdata_i[`LAT_MSB:`LAT_LSB];
    if (pci_cfg_wr_i && pci_cfg_idx_i == `CFG_IDX_SELFTEST_WORD && pci_cfg_be_i[1])
      master_latency_timer_next = pci_cfg_wdata_i[`LAT_MSB:`LAT_LSB];
  end

  // Next-state for I/O base; write data on fixed bits is dropped
  always @* begin
    io_base_next = io_base_reg;
    if (pp_wr_i && pp_idx_i == `CFG_IDX_IO_BASE_WORD)
      io_base_next = (io_base_next & ~(io_wmask & be_mask(pp_be_i)))
                   | (pp_wdata_i & io_wmask & be_mask(pp_be_i));
    if (pci_cfg_wr_i && pci_cfg_idx_i == `CFG_IDX_IO_BASE_WORD)
      io_base_next = (io_base_next & ~(io_wmask & be_mask(pci_cfg_be_i)))
                   | (pci_cfg_wdata_i & io_wmask & be_mask(pci_cfg_be_i));
  end

  // Both power-on and software reset restore initial values
  always @(posedge ref_clk_i) begin
    if (!rstn_i || !soft_rstn_i) begin
      master_latency_timer_reg <= `LAT_RESET;
      io_base_reg              <= `IO_BASE_RESET;
    end else begin
      master_latency_timer_reg <= master_latency_timer_next;
      io_base_reg              <= io_base_next;
    end
  end

  // Registered read data, one cycle after the strobe
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pci_cfg_rdata_o <= 32'h00000000;
      pp_rdata_o      <= 32'h00000000;
    end else begin
      if (pci_cfg_rd_i)
        pci_cfg_rdata_o <= cfg_read(pci_cfg_idx_i, selftest_word, io_base_word);
      if (pp_rd_i)
        pp_rdata_o <= cfg_read(pp_idx_i, selftest_word, io_base_word);
    end
  end

  // Latency value handed to the master sequencer
  always @(posedge ref_clk_i) begin
    if (!rstn_i)
      master_latency_timer_o <= `LAT_RESET;
    else
      master_latency_timer_o <= master_latency_timer_reg;
  end

  // Snoop signals have no effect; target is always uncached
  assign cache_disabled_o = 1'b1;

  // Host must have programmed the base before relying on hits
  io_window_decode u_decode (
    .io_base_i     (io_base_word),
    .ext_variant_i (variant_reg),
    .addr_i        (pci_io_addr_i),
    .io_cmd_i      (pci_io_cmd_i),
    .hit_o         (io_hit_o)
  );
endmodule // pci_config_header_io_base

/* File: verilog/pci_cfg_hdr_regs.vh */
// Offsets, field positions, masks and reset values of the two configuration words
`ifndef PCI_CFG_HDR_REGS_VH
`define PCI_CFG_HDR_REGS_VH
// Word indices within the configuration header
`define CFG_IDX_SELFTEST_WORD   6'h03
`define CFG_IDX_IO_BASE_WORD    6'h04
`define CFG_IDX_W               6
// Reset values
`define SELFTEST_WORD_RESET     32'h00000000
`define IO_BASE_RESET           32'h00000001
// Self-test / header field values
`define SELFTEST_CAPABLE_VAL    1'h0
`define SELFTEST_START_VAL      1'h0
`define SELFTEST_ZERO_VAL       2'h0
`define SELFTEST_CODE_PASS      4'h0
`define MULTIFUNCTION_VAL       1'h0
`define LAYOUT_TYPE_00          7'h00
`define CACHE_LINE_SIZE_VAL     8'h00
// Latency timer field
`define LAT_MSB                 15
`define LAT_LSB                 8
`define LAT_RESET               8'h00
// I/O base masks: writable bits per variant
`define IO_WMASK_BASE           32'h7FF00000
`define IO_WMASK_EXT            32'hFFFFFF00
`define IO_LOW_FIXED_VAL        6'h00
`define IO_RSVD_VAL             1'h0
`define IO_SPACE_IND_VAL        1'h1
// Decode masks for the I/O window (1 Mbyte and 256 bytes)
`define IO_DEC_MASK_BASE        32'hFFF00000
`define IO_DEC_MASK_EXT         32'hFFFFFF00
`endif

/* File: verilog/io_window_decode.v */
// Comparator that matches a PCI I/O address against the programmed window base
`timescale 1ns/10ps
`include "pci_cfg_hdr_regs.vh"
module io_window_decode (
  input  wire [31:0] io_base_i,    // Programmed base register value
  input  wire        ext_variant_i,// High selects 256-byte window
  input  wire [31:0] addr_i,       // PCI I/O address
  input  wire        io_cmd_i,     // I/O transfer command present
  output wire        hit_o         // Address falls inside window
);
  wire [31:0] dec_mask;

  // Window size follows the variant
  assign dec_mask = ext_variant_i ? `IO_DEC_MASK_EXT : `IO_DEC_MASK_BASE;
  assign hit_o    = io_cmd_i & ((addr_i & dec_mask) == (io_base_i & dec_mask));
endmodule // io_window_decode

/* File: test/pci_cfg_hdr_props.sv */
// Assertions watching the configuration header block ports
`timescale 1ns/10ps
module pci_cfg_hdr_props (
  input wire        ref_clk_i, rstn_i, soft_rstn_i, ext_variant_i, // Clock, resets, strap
  input wire        pci_cfg_wr_i, pci_cfg_rd_i, pp_wr_i, pp_rd_i,  // Strobes
  input wire        pci_io_cmd_i, io_hit_o, cache_disabled_o,      // Decode flags
  input wire [5:0]  pci_cfg_idx_i, pp_idx_i,                       // Word indices
  input wire [31:0] pci_cfg_rdata_o, pp_rdata_o, pci_io_addr_i,    // Data, address
  input wire [7:0]  master_latency_timer_o                         // Latency copy
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Reads taken only outside software reset
  wire rd3 = pci_cfg_rd_i && soft_rstn_i && pci_cfg_idx_i == 6'h03;
  wire rd4 = pci_cfg_rd_i && soft_rstn_i && pci_cfg_idx_i == 6'h04;
  AST_HDR_ZERO: assert property (rd3 |=> pci_cfg_rdata_o[31:16] == 16'h0000) else $error("Header bits set");
  AST_CACHE_ZERO: assert property (rd3 |=> pci_cfg_rdata_o[7:0] == 8'h00) else $error("Cache size set");
  AST_IO_LOW: assert property (rd4 |=> pci_cfg_rdata_o[7:0] == 8'h01) else $error("I/O base low bits wrong");
  AST_BASE_FIXED: assert property (pp_rd_i && soft_rstn_i && pp_idx_i == 6'h04 && !ext_variant_i
    |=> pp_rdata_o[31] == 1'b0 && pp_rdata_o[19:8] == 12'h000) else $error("Fixed base bits set");
  AST_NO_CACHE: assert property (cache_disabled_o) else $error("Cache not disabled");
  AST_LAT_COPY: assert property (rd3 && !pci_cfg_wr_i && !pp_wr_i
    |=> pci_cfg_rdata_o[15:8] == master_latency_timer_o) else $error("Latency copy differs");
  AST_RST_CLEAR: assert property ($rose(rstn_i) |-> pci_cfg_rdata_o == 32'h00000000
    && master_latency_timer_o == 8'h00) else $error("Reset state wrong");
  AST_RST_HIT: assert property ($rose(rstn_i) && pci_io_cmd_i && pci_io_addr_i[31:8] == 24'h000000
    |-> io_hit_o) else $error("No hit at reset base");
  AST_NO_CMD: assert property (!pci_io_cmd_i |-> !io_hit_o) else $error("Hit without command");
  AST_PORTS_AGREE: assert property (pci_cfg_rd_i && pp_rd_i && soft_rstn_i && pci_cfg_idx_i == pp_idx_i
    |=> pci_cfg_rdata_o == pp_rdata_o) else $error("Ports disagree");
  AST_SOFT_IO: assert property (!soft_rstn_i ##1 rd4 |=> pci_cfg_rdata_o == 32'h00000001)
    else $error("Soft reset base wrong");
endmodule // pci_cfg_hdr_props
bind pci_config_header_io_base pci_cfg_hdr_props pci_cfg_hdr_props_i (.ref_clk_i, .rstn_i, .soft_rstn_i,
  .ext_variant_i, .pci_cfg_wr_i, .pci_cfg_rd_i, .pp_wr_i, .pp_rd_i, .pci_io_cmd_i, .io_hit_o, .cache_disabled_o,
  .pci_cfg_idx_i, .pp_idx_i, .pci_cfg_rdata_o, .pp_rdata_o, .pci_io_addr_i, .master_latency_timer_o);

/* File: test/pci_host_model.sv */
// Behavioural PCI host issuing configuration and I/O cycles
`timescale 1ns/10ps
module pci_host_model (
  input  wire        clk_i,   // Clock
  input  wire [31:0] rdata_i, // Config read data
  output reg         wr_o,    // Write strobe
  output reg         rd_o,    // Read strobe
  output reg  [5:0]  idx_o,   // Word index
  output reg  [3:0]  be_o,    // Byte enables
  output reg  [31:0] wdata_o, // Write data
  output reg  [31:0] addr_o,  // I/O address
  output reg         cmd_o    // I/O command
);
  initial {wr_o, rd_o, idx_o, be_o, wdata_o, addr_o, cmd_o} = {44'h0, 32'h0, 1'b1};
  // One-cycle strobe; idle data inverted so stale values never pass
  task cfg(input w, input [5:0] i, input [3:0] b, input [31:0] d, output [31:0] q);
    @(negedge clk_i);
    {wr_o, rd_o, idx_o, be_o, wdata_o} = {w, !w, i, b, d & 32'hFFFFFFFD};
    @(negedge clk_i);
    {wr_o, rd_o, wdata_o} = {2'b00, ~wdata_o};
    q = rdata_i;
  endtask
  // I/O cycle on a falling edge; cmd_o is already high at address 0 from time zero, before any base is programmed
  task io(input c, input [31:0] a);
    @(negedge clk_i);
    {cmd_o, addr_o} = {c, a};
  endtask
endmodule // pci_host_model

/* File: test/tb_top.sv */
// Self-checking bench for the configuration header block
`timescale 1ns/10ps
module tb_top;
  reg         ref_clk_i = 1'b0, rstn_i = 1'b0, soft_rstn_i = 1'b1, ext_variant_i = 1'b0, pp_wr_i = 1'b0, pp_rd_i = 1'b0;
  reg  [5:0]  pp_idx_i = 6'h00;
  reg  [3:0]  pp_be_i = 4'h0;
  reg  [31:0] pp_wdata_i = 32'h00000000, q, r, m, sz;
  wire        pci_cfg_wr_i, pci_cfg_rd_i, pci_io_cmd_i, io_hit_o, cdis;
  wire [5:0]  pci_cfg_idx_i;
  wire [3:0]  pci_cfg_be_i;
  wire [31:0] pci_cfg_wdata_i, pci_cfg_rdata_o, pp_rdata_o, pci_io_addr_i;
  wire [7:0]  lat;
  integer     mismatches = 0, n_compared = 0, v;
  initial forever #2 ref_clk_i = ~ref_clk_i;
  pci_host_model pci_host_model_i (.clk_i(ref_clk_i), .rdata_i(pci_cfg_rdata_o), .wr_o(pci_cfg_wr_i),
    .rd_o(pci_cfg_rd_i), .idx_o(pci_cfg_idx_i), .be_o(pci_cfg_be_i), .wdata_o(pci_cfg_wdata_i),
    .addr_o(pci_io_addr_i), .cmd_o(pci_io_cmd_i));
  pci_config_header_io_base pci_config_header_io_base_i (.ref_clk_i, .rstn_i, .soft_rstn_i, .ext_variant_i,
    .pci_cfg_wr_i, .pci_cfg_rd_i, .pci_cfg_idx_i, .pci_cfg_be_i, .pci_cfg_wdata_i, .pci_cfg_rdata_o, .pp_wr_i,
    .pp_rd_i, .pp_idx_i, .pp_be_i, .pp_wdata_i, .pp_rdata_o, .pci_io_addr_i, .pci_io_cmd_i, .io_hit_o,
    .master_latency_timer_o(lat), .cache_disabled_o(cdis));
  task chk(input [31:0] g, input [31:0] e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Peripheral bus cycle, same shape as the host's
  task pp(input w, input [5:0] i, input [3:0] b, input [31:0] d);
    @(negedge ref_clk_i);
    {pp_wr_i, pp_rd_i, pp_idx_i, pp_be_i, pp_wdata_i} = {w, !w, i, b, d};
    @(negedge ref_clk_i);
    {pp_wr_i, pp_rd_i, pp_wdata_i} = {2'b00, ~pp_wdata_i};
    q = pp_rdata_o;
  endtask
  task stop_test;
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the roughly 80 cycles needed
  initial begin
    #20000;
    mismatches = mismatches + 1;
    stop_test;
  end
  // Each variant is latched from the strap during reset
  initial begin
    for (v = 0; v < 2; v = v + 1) begin
      rstn_i = 1'b0;
      ext_variant_i = v[0];
      repeat (16) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      m = v ? 32'hFFFFFF00 : 32'h7FF00000;
      sz = v ? 32'h00000100 : 32'h00100000;
      pci_host_model_i.cfg(0, 6'h03, 4'hF, 32'h0, q); chk(q, 32'h0);
      pp(0, 6'h04, 4'hF, 32'h0); chk(q, 32'h00000001);
      pci_host_model_i.cfg(1, 6'h04, 4'hF, 32'hFFFFFFFF, q);
      pp(1, 6'h03, 4'hF, 32'hFFFFFFFF);
      pp(1, 6'h03, 4'hD, 32'h0);
      fork
        pci_host_model_i.cfg(0, 6'h04, 4'hF, 32'h0, r);
        pp(0, 6'h04, 4'hF, 32'h0);
      join
      chk(r, m | 32'h1);
      chk(q, m | 32'h1);
      pci_host_model_i.cfg(0, 6'h03, 4'hF, 32'h0, q); chk(q, 32'h0000FF00);
      chk({24'h0, lat}, 32'h000000FF);
      pp(0, 6'h07, 4'hF, 32'h0); chk(q, 32'h0);
      pci_host_model_i.io(1, m + sz - 1); #1 chk({31'h0, io_hit_o}, 32'h1);
      pci_host_model_i.io(1, m - 1); #1 chk({31'h0, io_hit_o}, 32'h0);
      pci_host_model_i.io(0, m); #1 chk({31'h0, io_hit_o}, 32'h0);
      @(negedge ref_clk_i) soft_rstn_i = 1'b0;
      fork
        pci_host_model_i.cfg(0, 6'h04, 4'hF, 32'h0, r);
        @(negedge ref_clk_i) soft_rstn_i = 1'b1;
      join
      chk(r, 32'h00000001);
      pp(0, 6'h03, 4'hF, 32'h0); chk(q, 32'h0);
    end
    stop_test;
  end
endmodule // tb_top
